/* ckcf_defines.vh */
// ckcf_defines.vh: constants of the clock generator configuration front end
// assumes: included by its bare name from the design files
`ifndef CKCF_DEFINES_VH
`define CKCF_DEFINES_VH
`define CKCF_CLK_MHZ 50
`define CKCF_STRAP_WIN_US 2000
`define CKCF_STRAP_WIN_CYC (`CKCF_STRAP_WIN_US * `CKCF_CLK_MHZ)
`define CKCF_SLAVE_ADDR 8'hD2
`define CKCF_NUM_BYTES 11
`define CKCF_NUM_DATA 8
`define CKCF_FIRST_DATA 4'h3
`define CKCF_BYTE0_RST 8'h04
`define CKCF_BYTEN_RST 8'hFF
`define CKCF_BYTE3_RST 8'h00
`define CKCF_OE_RST 16'hFFFF
`define CKCF_BIT_SW_SEL 3
`define CKCF_BYTE_SSC 0
`define CKCF_BYTE_SEL 0
`define CKCF_BYTE_OE_LO 1
`define CKCF_BYTE_OE_HI 2
`define CKCF_BYTE_TRI 3
`define CKCF_RAMP_CYC 16'h0400
`endif

/* ckcf_cfg_mem.v */
// ckcf_cfg_mem.v: eight-byte configuration store with registered read
// assumes: single clock, synchronous active-high power-on reset
`timescale 1ns/1ns
`include "ckcf_defines.vh"
module ckcf_cfg_mem (
   input wire core_clk_i,
   input wire sys_rst_i,
   input wire wr_en_i,
   input wire [2:0] wr_addr_i,
   input wire [7:0] wr_data_i,
   input wire commit_i,
   output reg [63:0] rd_data_o
);
   reg [7:0] mem_q [0:7];
   integer i;
   // staged bytes only become visible on commit; defaults at reset
   always @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         // the three-state mask defaults to zero so an unconfigured part still drives
         for (i = 0; i < 8; i = i + 1) begin
            if (i == 0) begin
               mem_q[i] <= `CKCF_BYTE0_RST;
            end else if (i == `CKCF_BYTE_TRI) begin
               mem_q[i] <= `CKCF_BYTE3_RST;
            end else begin
               mem_q[i] <= `CKCF_BYTEN_RST;
            end
         end
      end else if (wr_en_i) begin
         mem_q[wr_addr_i] <= wr_data_i;
      end
   end
   always @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         rd_data_o <= {{4{`CKCF_BYTEN_RST}}, `CKCF_BYTE3_RST, {2{`CKCF_BYTEN_RST}},
                       `CKCF_BYTE0_RST};
      end else if (commit_i) begin
         rd_data_o <= {mem_q[7], mem_q[6], mem_q[5], mem_q[4],
                       mem_q[3], mem_q[2], mem_q[1], mem_q[0]};
      end
   end
endmodule

/* ckcf_top.v */
// ckcf_top.v: strap capture and write-only serial configuration loader
// assumes: sys_rst_i is the power-on reset; serial pins are asynchronous
// assumes: the serial controller sends no acknowledge slot
`timescale 1ns/1ns
`include "ckcf_defines.vh"
module ckcf_top #(
   parameter STRAP_WIN_CYC = `CKCF_STRAP_WIN_CYC,
   parameter RAMP_CYC = `CKCF_RAMP_CYC
) (
   input wire core_clk_i,
   input wire sys_rst_i,
   input wire power_good_i,
   input wire [4:0] strap_pin_i,
   output reg [4:0] strap_pin_oe_n_o,
   output reg [4:0] strap_val_o,
   output reg strap_valid_o,
   output reg short_cycle_ok_o,
   input wire serial_clock_pin_i,
   input wire serial_data_pin_i,
   output reg serial_data_pin_o,
   output reg serial_data_pin_oe_n_o,
   output reg [3:0] frequency_select_straps_o,
   output reg [4:0] freq_sel_o,
   output reg freq_sw_sel_o,
   output reg ramp_busy_o,
   output reg ssc_cpu_en_o,
   output reg ssc_pci_en_o,
   output reg [15:0] clk_out_en_o,
   output reg [7:0] clk_out_tri_o
);
   localparam ST_IDLE = 2'd0;
   localparam ST_RECV = 2'd1;
   localparam ST_SKIP = 2'd2;

   // frequency select code {fs3, fs2, fs1, fs0} as taken from the five strap bits
   function [3:0] fs_map;
      input [4:0] s;
      begin
         fs_map = {s[3], s[2], s[1], s[4]};
      end
   endfunction

   // committed byte 0 to the five-bit select code {sel4, sel3, sel2, sel1, sel0}
   function [4:0] sel_code;
      input [7:0] b;
      begin
         sel_code = {b[2], b[1], b[6], b[5], b[4]};
      end
   endfunction

   // two-flop synchronisers on every pin input
   // third flops on clock and data keep the history for edge, start and stop
   reg [4:0] strap_m_q, strap_s_q;
   reg pg_m_q, pg_s_q;
   reg scl_m_q, scl_s_q, scl_d_q;
   reg sda_m_q, sda_s_q, sda_d_q;
   always @(posedge core_clk_i) begin
      strap_m_q <= strap_pin_i;
      strap_s_q <= strap_m_q;
      pg_m_q <= power_good_i;
      pg_s_q <= pg_m_q;
      scl_m_q <= serial_clock_pin_i;
      scl_s_q <= scl_m_q;
      scl_d_q <= scl_s_q;
      sda_m_q <= serial_data_pin_i;
      sda_s_q <= sda_m_q;
      sda_d_q <= sda_s_q;
   end

   // strap window: only power-on reset clears it, serial traffic never touches it
   // power good dropping mid-window freezes the count; it resumes rather than restarts
   reg [31:0] win_cnt_q;
   reg latched_q;
   always @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         win_cnt_q <= 32'h0000_0000;
         latched_q <= 1'b0;
         strap_val_o <= 5'h00;
         strap_valid_o <= 1'b0;
         strap_pin_oe_n_o <= 5'h1F;
         short_cycle_ok_o <= 1'b0;
         frequency_select_straps_o <= 4'h0;
      end else begin
         short_cycle_ok_o <= 1'b0;
         if (!latched_q && pg_s_q) begin
            if (win_cnt_q == STRAP_WIN_CYC - 1) begin
               latched_q <= 1'b1;
               strap_val_o <= strap_s_q;
               strap_valid_o <= 1'b1;
               frequency_select_straps_o <= fs_map(strap_s_q);
            end else begin
               win_cnt_q <= win_cnt_q + 32'd1;
            end
         end
         // drivers turn on one edge after the latch, so the level sampled is never ours
         if (latched_q && strap_valid_o && strap_pin_oe_n_o != 5'h00) begin
            strap_pin_oe_n_o <= 5'h00;
            short_cycle_ok_o <= 1'b1;
         end
      end
   end

   // serial receiver; start and stop detected from data edges while clock high
   wire scl_rise = scl_s_q & ~scl_d_q;
   wire start_c = scl_s_q & scl_d_q & sda_d_q & ~sda_s_q;
   wire stop_c = scl_s_q & scl_d_q & ~sda_d_q & sda_s_q;
   reg [1:0] st_q, st_d;
   reg [7:0] shift_q, shift_d;
   reg [2:0] bit_q, bit_d;
   reg [3:0] byte_q, byte_d;
   reg wr_en_q, wr_en_d;
   reg last_q, last_d;
   reg commit_q;
   reg [2:0] wr_addr_q, wr_addr_d;
   reg [7:0] wr_data_q, wr_data_d;
   wire [63:0] cfg_w;

   // byte as it stands once the bit now on the data pin is shifted in, msb first
   function [7:0] shift_in;
      input [7:0] sh;
      input din;
      begin
         shift_in = {sh[6:0], din};
      end
   endfunction

   // store slot of a data byte; bytes before the first data byte never get here
   function [2:0] data_slot;
      input [3:0] pos;
      reg [3:0] rel;
      begin
         rel = pos - `CKCF_FIRST_DATA;
         data_slot = rel[2:0];
      end
   endfunction

   wire [7:0] rx_byte = shift_in(shift_q, sda_s_q);

   // next state of the receiver; wr_en and last are single-cycle strobes
   always @* begin
      st_d = st_q;
      shift_d = shift_q;
      bit_d = bit_q;
      byte_d = byte_q;
      wr_en_d = 1'b0;
      last_d = 1'b0;
      wr_addr_d = wr_addr_q;
      wr_data_d = wr_data_q;
      case (st_q)
         ST_IDLE: begin
            // only a start leaves idle; stray clock edges are ignored
            if (start_c) begin
               st_d = ST_RECV;
               bit_d = 3'h0;
               byte_d = 4'h0;
            end
         end
         ST_RECV: begin
            if (start_c) begin
               // a repeated start opens a new frame at the address byte
               bit_d = 3'h0;
               byte_d = 4'h0;
            end else if (stop_c) begin
               // a cut frame ends here and commits nothing
               st_d = ST_IDLE;
            end else if (scl_rise) begin
               shift_d = rx_byte;
               bit_d = bit_q + 3'h1;
               if (bit_q == 3'h7) begin
                  byte_d = byte_q + 4'h1;
                  if (byte_q == 4'h0 && rx_byte != `CKCF_SLAVE_ADDR) begin
                     st_d = ST_SKIP;
                  end
                  if (byte_q >= `CKCF_FIRST_DATA) begin
                     wr_en_d = 1'b1;
                     wr_addr_d = data_slot(byte_q);
                     wr_data_d = rx_byte;
                  end
                  if (byte_q == `CKCF_NUM_BYTES - 1) begin
                     last_d = 1'b1;
                     st_d = ST_IDLE;
                  end
               end
            end
         end
         ST_SKIP: begin
            // foreign frame: bits pass by unseen until the next start or stop
            if (start_c) begin
               st_d = ST_RECV;
               bit_d = 3'h0;
               byte_d = 4'h0;
            end else if (stop_c) begin
               st_d = ST_IDLE;
            end
         end
         default: begin
            st_d = ST_IDLE;
         end
      endcase
   end

   // receiver registers; wr_en_q, last_q and commit_q are one clock wide
   always @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         st_q <= ST_IDLE;
         shift_q <= 8'h00;
         bit_q <= 3'h0;
         byte_q <= 4'h0;
         wr_en_q <= 1'b0;
         last_q <= 1'b0;
         commit_q <= 1'b0;
         wr_addr_q <= 3'h0;
         wr_data_q <= 8'h00;
      end else begin
         st_q <= st_d;
         shift_q <= shift_d;
         bit_q <= bit_d;
         byte_q <= byte_d;
         wr_en_q <= wr_en_d;
         last_q <= last_d;
         // commit trails the last store by one edge, so data byte 7 is in the store
         commit_q <= last_q;
         wr_addr_q <= wr_addr_d;
         wr_data_q <= wr_data_d;
      end
   end
   // acknowledge bit is not modelled as a separate phase: the controller side
   // clocks eight bits per byte; the data pin driver stays off permanently
   always @(posedge core_clk_i) begin
      serial_data_pin_o <= 1'b0;
      serial_data_pin_oe_n_o <= 1'b1;
   end

   ckcf_cfg_mem u_mem (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .wr_en_i(wr_en_q),
      .wr_addr_i(wr_addr_q),
      .wr_data_i(wr_data_q),
      .commit_i(commit_q),
      .rd_data_o(cfg_w)
   );

   // decode committed bytes; ramp holds select changes for a settle period
   // the hold is not a frequency walk: the synthesizer slews while ramp_busy_o is high
   // a new target seen mid-ramp is taken at the end of the same hold
   wire [7:0] b0 = cfg_w[7:0];
   wire [4:0] sel_tgt = sel_code(b0);
   reg [15:0] ramp_q;
   always @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         freq_sel_o <= 5'h00;
         freq_sw_sel_o <= 1'b0;
         ramp_busy_o <= 1'b0;
         ramp_q <= 16'h0000;
         ssc_cpu_en_o <= 1'b0;
         ssc_pci_en_o <= 1'b0;
         // enable and three-state reset values equal the store defaults; freq_sel_o resets to 0 and ramps to the default
         clk_out_en_o <= `CKCF_OE_RST;
         clk_out_tri_o <= `CKCF_BYTE3_RST;
      end else begin
         freq_sw_sel_o <= b0[`CKCF_BIT_SW_SEL];
         if (sel_tgt != freq_sel_o && !ramp_busy_o) begin
            ramp_busy_o <= 1'b1;
            ramp_q <= RAMP_CYC[15:0];
         end else if (ramp_busy_o) begin
            if (ramp_q == 16'h0000) begin
               ramp_busy_o <= 1'b0;
               freq_sel_o <= sel_tgt;
            end else begin
               ramp_q <= ramp_q - 16'h0001;
            end
         end
         // cpu and pci share one spread enable; no other output is modulated
         ssc_cpu_en_o <= b0[1:0] != 2'b00;
         ssc_pci_en_o <= b0[1:0] != 2'b00;
         // enable and three-state masks follow the store directly; only freq_sel_o ramps
         clk_out_en_o <= cfg_w[23:8];
         clk_out_tri_o <= cfg_w[31:24];
      end
   end
endmodule

/* ckcf_top_props.sv */
// ckcf_top_props.sv: port checker for the loader
// assumes: bound to ckcf_top, sync high reset
`timescale 1ns/1ns
module ckcf_top_props #(
   parameter STRAP_WIN_CYC = 50
) (
   input wire core_clk_i,
   input wire sys_rst_i,
   input wire power_good_i,
   input wire [4:0] strap_pin_oe_n_o,
   input wire [4:0] strap_val_o,
   input wire strap_valid_o,
   input wire short_cycle_ok_o,
   input wire serial_data_pin_oe_n_o,
   input wire [4:0] freq_sel_o,
   input wire ramp_busy_o,
   input wire ssc_cpu_en_o,
   input wire ssc_pci_en_o
);
   default clocking @(posedge core_clk_i);
   endclocking
   default disable iff (sys_rst_i);
   // cycles with power good seen; the sync flops add a little slack
   reg [31:0] pg_q;
   always @(posedge core_clk_i) pg_q <= sys_rst_i ? 32'h0 : pg_q + power_good_i;
   a_pins_float: assert property (!strap_valid_o |-> strap_pin_oe_n_o == 5'h1f)
      else $error("strap pin driven early");
   a_straps_kept: assert property (strap_valid_o |=> strap_valid_o && $stable(strap_val_o))
      else $error("straps changed");
   a_drive_after: assert property ($rose(strap_valid_o) |=> strap_pin_oe_n_o == 5'h00)
      else $error("drivers not enabled");
   a_short_pulse: assert property ($rose(strap_valid_o) |=> short_cycle_ok_o ##1 !short_cycle_ok_o)
      else $error("bad short pulse");
   a_window_len: assert property ($rose(strap_valid_o) |->
      pg_q >= STRAP_WIN_CYC && pg_q <= STRAP_WIN_CYC + 4)
      else $error("window length wrong");
   a_write_only: assert property (serial_data_pin_oe_n_o)
      else $error("data line driven");
   a_spread_pair: assert property (ssc_cpu_en_o == ssc_pci_en_o)
      else $error("spread enables differ");
   a_ramp_first: assert property ($changed(freq_sel_o) |-> $past(ramp_busy_o))
      else $error("frequency stepped");
   c_latch: cover property ($rose(strap_valid_o));
   c_ramp: cover property ($fell(ramp_busy_o));
   c_spread: cover property ($rose(ssc_cpu_en_o));
endmodule

/* ckcf_host.sv */
// ckcf_host.sv: chipset model driving the write port
// assumes: data line pulled up, no acknowledge slot
`timescale 1ns/1ns
module ckcf_host (
   output logic scl_o,
   output logic sda_o
);
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   // clock stands high between frames; n bytes go out before the stop
   task send(input [7:0] adr, input [63:0] dat, input integer n);
      reg [87:0] f;
      integer i;
      begin
         f = {adr, 8'h5a, 8'h08, dat};
         #7 sda_o = 1'b0;
         #80 scl_o = 1'b0;
         for (i = 87; i > 87 - 8 * n; i = i - 1) begin
            #40 sda_o = f[i];
            #40 scl_o = 1'b1;
            #80 scl_o = 1'b0;
         end
         #40 sda_o = 1'b0;
         #40 scl_o = 1'b1;
         #80 sda_o = 1'b1;
      end
   endtask
endmodule

/* test_ckcf_top.sv */
// test_ckcf_top.sv: directed bench for straps and serial loads
// assumes: design, host model and checker compiled first
`timescale 1ns/1ns
module test_ckcf_top;
   localparam W = 50;
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg pg = 1'b0;
   reg [4:0] pin = 5'h16;
   wire scl, sda_h, sdo, sdo_oe_n, vld, sc, sw, busy, sc_c, sc_p;
   wire [4:0] oe_n, sval, fsel;
   wire [3:0] fss;
   wire [15:0] en;
   wire [7:0] tri3;
   integer fail_count = 0;
   integer checks = 0;
   wire sda = sda_h & (sdo_oe_n | sdo);
   always #10 clk = ~clk;
   ckcf_host host (.scl_o(scl), .sda_o(sda_h));
   ckcf_top #(.STRAP_WIN_CYC(W), .RAMP_CYC(4)) uut (.core_clk_i(clk), .sys_rst_i(rst),
      .power_good_i(pg), .strap_pin_i(pin), .strap_pin_oe_n_o(oe_n), .strap_val_o(sval),
      .strap_valid_o(vld), .short_cycle_ok_o(sc), .serial_clock_pin_i(scl),
      .serial_data_pin_i(sda), .serial_data_pin_o(sdo), .serial_data_pin_oe_n_o(sdo_oe_n),
      .frequency_select_straps_o(fss), .freq_sel_o(fsel), .freq_sw_sel_o(sw),
      .ramp_busy_o(busy), .ssc_cpu_en_o(sc_c), .ssc_pci_en_o(sc_p), .clk_out_en_o(en),
      .clk_out_tri_o(tri3));
   task chk(input [15:0] seen, input [15:0] exp, input string name);
      begin
         checks = checks + 1;
         if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("mismatch %0s exp %h seen %h", name, exp, seen);
         end
      end
   endtask
   // waits past the ramp, then checks every configured output but the pci spread enable
   task cfg(input [7:0] b0, input [15:0] e, input [7:0] t);
      begin
         repeat (30) @(posedge clk);
         #2 chk(en, e, "en");
         chk(tri3, t, "tri");
         chk(sc_c, b0[1:0] != 2'b00, "ssc");
         chk(fsel, {b0[2], b0[1], b0[6:4]}, "fsel");
         chk(sw, b0[3], "swsel");
      end
   endtask
   task end_sim;
      begin
         $display("checks %0d mismatches %0d", checks, fail_count);
         if (fail_count == 0 && checks > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   initial begin
      #400000;
      fail_count = fail_count + 1;
      end_sim;
   end
   initial begin
      repeat (6) @(posedge clk);
      #2 rst = 1'b0;
      repeat (5) @(posedge clk);
      #2 chk(oe_n, 5'h1f, "oe_early");
      chk(en, 16'hffff, "en_dflt");
      chk(sc_c, 1'b0, "ssc_dflt");
      chk(tri3, 8'h00, "tri_dflt");
      chk({sdo_oe_n, sdo}, 2'b10, "sda_drv");
      pg = 1'b1;
      repeat (W - 5) @(posedge clk);
      #2 chk(vld, 1'b0, "valid_early");
      chk(fsel, 5'h10, "fsel_dflt");
      repeat (20) @(posedge clk);
      #2 chk(sval, 5'h16, "straps");
      chk(oe_n, 5'h00, "oe_late");
      chk(fss, 4'h7, "fs_straps");
      pin = 5'h09;
      host.send(8'hd2, 64'h3ba5_3c0f_0000_0000, 11);
      cfg(8'h3b, 16'h3ca5, 8'h0f);
      chk(sval, 5'h16, "straps_kept");
      host.send(8'hd0, 64'h0400_0000_0000_0000, 11);
      cfg(8'h3b, 16'h3ca5, 8'h0f);
      host.send(8'hd2, 64'h0400_0000_0000_0000, 9);
      cfg(8'h3b, 16'h3ca5, 8'h0f);
      host.send(8'hd2, 64'h0400_0000_0000_0000, 11);
      cfg(8'h04, 16'h0000, 8'h00);
      end_sim;
   end
endmodule
bind ckcf_top ckcf_top_props #(.STRAP_WIN_CYC(STRAP_WIN_CYC)) u_props (
   .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .power_good_i(power_good_i),
   .strap_pin_oe_n_o(strap_pin_oe_n_o), .strap_val_o(strap_val_o),
   .strap_valid_o(strap_valid_o), .short_cycle_ok_o(short_cycle_ok_o),
   .serial_data_pin_oe_n_o(serial_data_pin_oe_n_o), .freq_sel_o(freq_sel_o),
   .ramp_busy_o(ramp_busy_o), .ssc_cpu_en_o(ssc_cpu_en_o), .ssc_pci_en_o(ssc_pci_en_o));
